// *** rtl/fcsu_pkg.sv ***
// Package of constants and carrier types for the flow-control serialize unit.
package fcsu_pkg;
   localparam int unsigned OPC_MSB = 31;
   localparam int unsigned OPC_LSB = 24;
   localparam int unsigned FLAG_MEM_BIT = 23;
   localparam int unsigned FLAG_EXEC_BIT = 22;
   localparam int unsigned FLAG_BACKUP_BIT = 21;
   localparam int unsigned FLAG_FLUSH_BIT = 20;
   localparam int unsigned RSVD_MSB = 19;
   localparam logic [7:0] DEF_IDLE_OPC = 8'h10;
   localparam logic [7:0] DEF_RETURN_OPC = 8'h11;
   localparam logic [7:0] DEF_SAVE_OPC = 8'h12;
   localparam logic [7:0] DEF_RESTORE_OPC = 8'h13;
   localparam logic [7:0] DEF_BARRIER_OPC = 8'h14;
   localparam logic LITTLE_ENDIAN_DEFAULT = 1'b1;

   typedef struct packed {
      logic mem_idle;
      logic exec_idle;
      logic backup_idle;
      logic flush_done;
   } fcsu_core_status_t;

   typedef struct packed {
      logic task_switch;
      logic context_return;
      logic early_save;
      logic early_restore;
   } fcsu_backup_cmd_t;
endpackage

// *** rtl/fcsu_flow_control.sv ***
// Flow-control instruction decoder, idle state and serialize barrier.
`timescale 1ns/1ps

// How it works
// - Idle instruction with zero low field stops the core until an exception.
// - Idle in user mode yields the slice and starts a backup task switch.
// - Exception return tells the backup engine to restore the previous task.
// - Early save starts a background context save; execution continues.
// - Early restore starts a background context prefetch of the last task.
// - Barrier holds issue until every selected condition holds together.
// - Memory flag waits for finished transactions and free load/store lines.
// - Execution flag waits for idle units and a clear scoreboard.
// - Backup flag waits until no backup activity or smooth switch pends.
// - Flush flag flushes the whole level-0 load/store cache first.
// - Memory accesses default to little-endian byte order.
// - Backup engine works in background and reorders urgent registers.
module fcsu_flow_control #(
   parameter logic [7:0] IDLE_OPCODE = fcsu_pkg::DEF_IDLE_OPC,
   parameter logic [7:0] EXCEPTION_RETURN_OPCODE = fcsu_pkg::DEF_RETURN_OPC,
   parameter logic [7:0] EARLY_SAVE_OPCODE = fcsu_pkg::DEF_SAVE_OPC,
   parameter logic [7:0] EARLY_RESTORE_OPCODE = fcsu_pkg::DEF_RESTORE_OPC,
   parameter logic [7:0] BARRIER_OPCODE = fcsu_pkg::DEF_BARRIER_OPC
) (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic instr_valid,
   input wire logic [31:0] instr_word,
   input wire logic user_mode,
   input wire logic exception_req,
   input wire fcsu_pkg::fcsu_core_status_t core_status,
   output logic instr_taken,
   output logic issue_hold,
   output logic core_idle,
   output logic illegal_instr,
   output logic lsu_flush_req,
   output fcsu_pkg::fcsu_backup_cmd_t backup_cmd,
   output logic little_endian
);
   import fcsu_pkg::*;

   typedef enum logic [2:0] {
      ST_RUN = 3'b001,
      ST_IDLE = 3'b010,
      ST_BARRIER = 3'b100
   } fcsu_state_t;

   fcsu_state_t state_q;
   fcsu_state_t state_d;
   logic [3:0] flags_q;
   logic flush_pend_q;
   fcsu_backup_cmd_t cmd_d;
   fcsu_backup_cmd_t cmd_q;
   logic illegal_d;
   logic illegal_q;
   logic barrier_met;
   logic [7:0] opc;
   logic low_zero;
   logic hit_idle;
   logic hit_return;
   logic hit_save;
   logic hit_restore;
   logic hit_barrier;

   function automatic logic rsvd_zero(input logic [31:0] w);
      rsvd_zero = (w[RSVD_MSB:0] == 20'h00000);
   endfunction

   // A shared opcode value would let one word start two actions, so a
   // parameter set with any two opcodes equal is refused at elaboration.
   if (IDLE_OPCODE == EXCEPTION_RETURN_OPCODE ||
       IDLE_OPCODE == EARLY_SAVE_OPCODE ||
       IDLE_OPCODE == EARLY_RESTORE_OPCODE ||
       IDLE_OPCODE == BARRIER_OPCODE ||
       EXCEPTION_RETURN_OPCODE == EARLY_SAVE_OPCODE ||
       EXCEPTION_RETURN_OPCODE == EARLY_RESTORE_OPCODE ||
       EXCEPTION_RETURN_OPCODE == BARRIER_OPCODE ||
       EARLY_SAVE_OPCODE == EARLY_RESTORE_OPCODE ||
       EARLY_SAVE_OPCODE == BARRIER_OPCODE ||
       EARLY_RESTORE_OPCODE == BARRIER_OPCODE) begin : g_opcode_clash
      $error("Flow-control opcodes must all differ.");
   end

   assign opc = instr_word[OPC_MSB:OPC_LSB];
   assign low_zero = (instr_word[OPC_LSB-1:0] == 24'h000000);

   // Each opcode compare feeds its own branch, and all but the barrier one also feed
   // the malformed-word catch, so each is decoded once here.
   assign hit_idle = (opc == IDLE_OPCODE);
   assign hit_return = (opc == EXCEPTION_RETURN_OPCODE);
   assign hit_save = (opc == EARLY_SAVE_OPCODE);
   assign hit_restore = (opc == EARLY_RESTORE_OPCODE);
   assign hit_barrier = (opc == BARRIER_OPCODE);

   // Each selected condition must hold; unselected ones pass.
   always_comb begin
      barrier_met = 1'b1;
      if (flags_q[3] && !core_status.mem_idle) begin
         barrier_met = 1'b0;
      end
      if (flags_q[2] && !core_status.exec_idle) begin
         barrier_met = 1'b0;
      end
      if (flags_q[1] && !core_status.backup_idle) begin
         barrier_met = 1'b0;
      end
      if (flags_q[0] && (flush_pend_q || !core_status.flush_done)) begin
         barrier_met = 1'b0;
      end
   end

   // Instructions are accepted only while running; the idle and barrier
   // states hold the issue stage so nothing slips past them.
   assign instr_taken = instr_valid && (state_q == ST_RUN);
   assign issue_hold = (state_q != ST_RUN);
   assign core_idle = (state_q == ST_IDLE);

   always_comb begin
      state_d = state_q;
      cmd_d = '0;
      illegal_d = 1'b0;
      case (state_q)
         ST_RUN: begin
            if (instr_taken) begin
               if (hit_idle && low_zero) begin
                  state_d = ST_IDLE;
                  cmd_d.task_switch = user_mode;
               end else if (hit_return && low_zero) begin
                  cmd_d.context_return = 1'b1;
               end else if (hit_save && low_zero) begin
                  cmd_d.early_save = 1'b1;
               end else if (hit_restore && low_zero) begin
                  cmd_d.early_restore = 1'b1;
               end else if (hit_barrier) begin
                  if (rsvd_zero(instr_word)) begin
                     state_d = ST_BARRIER;
                  end else begin
                     illegal_d = 1'b1;
                  end
               end else if (hit_idle || hit_return || hit_save ||
                            hit_restore) begin
                  illegal_d = 1'b1;
               end
            end
         end
         ST_IDLE: begin
            // Only an exception ends idle; new words stay refused meanwhile.
            if (exception_req) begin
               state_d = ST_RUN;
            end
         end
         ST_BARRIER: begin
            if (barrier_met) begin
               state_d = ST_RUN;
            end
         end
         default: begin
            state_d = ST_RUN;
         end
      endcase
   end

   // Reset returns to running so a reset never leaves issue held.
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         state_q <= ST_RUN;
      end else begin
         state_q <= state_d;
      end
   end

   // Flags are latched at decode so the barrier is immune to later words.
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         flags_q <= 4'h0;
      end else if (state_q == ST_RUN && state_d == ST_BARRIER) begin
         flags_q <= instr_word[FLAG_MEM_BIT:FLAG_FLUSH_BIT];
      end else if (state_q == ST_BARRIER && barrier_met) begin
         flags_q <= 4'h0;
      end
   end

   // The flush request is a single pulse; the flag stays pending for that cycle
   // and the next, so a stale done level cannot end the barrier.
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         flush_pend_q <= 1'b0;
         lsu_flush_req <= 1'b0;
      end else begin
         lsu_flush_req <= 1'b0;
         if (state_q == ST_RUN && state_d == ST_BARRIER &&
             instr_word[FLAG_FLUSH_BIT]) begin
            lsu_flush_req <= 1'b1;
            flush_pend_q <= 1'b1;
         end else if (flush_pend_q && !lsu_flush_req) begin
            flush_pend_q <= 1'b0;
         end
      end
   end

   // Backup commands are one-cycle pulses; the engine latches what it needs.
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         cmd_q <= '0;
      end else begin
         cmd_q <= cmd_d;
      end
   end

   // A malformed word is flagged for one cycle and otherwise acts as a no-op.
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         illegal_q <= 1'b0;
      end else begin
         illegal_q <= illegal_d;
      end
   end

   assign backup_cmd = cmd_q;
   assign illegal_instr = illegal_q;
   // Byte order is fixed; no mode bit selects the other order.
   assign little_endian = LITTLE_ENDIAN_DEFAULT;
endmodule // fcsu_flow_control

// *** verification/fcsu_checker.sv ***
// Port assertions for the flow-control serialize unit.
`timescale 1ns/1ps
module fcsu_checker import fcsu_pkg::*; (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic instr_valid,
   input wire logic [31:0] instr_word,
   input wire logic user_mode,
   input wire logic exception_req,
   input wire logic instr_taken,
   input wire logic issue_hold,
   input wire logic core_idle,
   input wire logic illegal_instr,
   input wire logic lsu_flush_req,
   input wire fcsu_backup_cmd_t backup_cmd,
   input wire logic little_endian
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   wire tk = instr_valid && instr_taken;
   wire [7:0] op = instr_word[31:24];
   wire z = instr_word[23:0] == 24'h0;
   chk_idle_enter: assert property (tk && op == DEF_IDLE_OPC && z
      && !exception_req |=> core_idle) else $error("idle not entered");
   chk_idle_wake: assert property (core_idle && resetn
      |=> core_idle == !$past(exception_req)) else $error("idle exit wrong");
   chk_task_switch: assert property (tk && op == DEF_IDLE_OPC && z
      |=> backup_cmd.task_switch == $past(user_mode)) else $error("switch");
   chk_return_cmd: assert property (tk && op == DEF_RETURN_OPC && z
      |=> backup_cmd.context_return) else $error("return command missed");
   chk_save_runs: assert property (tk && op == DEF_SAVE_OPC && z
      |=> backup_cmd.early_save && !issue_hold) else $error("save wrong");
   chk_restore_cmd: assert property (tk && op == DEF_RESTORE_OPC
      && z |=> backup_cmd.early_restore)
      else $error("restore command missed");
   chk_hold_refuse: assert property (issue_hold |-> !instr_taken)
      else $error("taken while held");
   chk_flush_pulse: assert property (tk && op == DEF_BARRIER_OPC
      && instr_word[20:0] == 21'h100000 |=> lsu_flush_req && issue_hold)
      else $error("flush missed");
   chk_byte_order: assert property (little_endian)
      else $error("byte order");
   chk_rsvd_refuse: assert property (tk && op == DEF_BARRIER_OPC
      && instr_word[19:0] != 20'h0 |=> illegal_instr && !issue_hold)
      else $error("reserved barrier bits accepted");
   chk_hold_cause: assert property ($rose(issue_hold) |-> $past(tk))
      else $error("hold without a taken word");
   cover property (core_idle && exception_req);
   cover property (lsu_flush_req);
   cover property ($fell(issue_hold));
endmodule // fcsu_checker
bind fcsu_flow_control fcsu_checker i_fcsu_checker (
   .sys_clk(sys_clk),
   .resetn(resetn),
   .instr_valid(instr_valid),
   .instr_word(instr_word),
   .user_mode(user_mode),
   .exception_req(exception_req),
   .instr_taken(instr_taken),
   .issue_hold(issue_hold),
   .core_idle(core_idle),
   .illegal_instr(illegal_instr),
   .lsu_flush_req(lsu_flush_req),
   .backup_cmd(backup_cmd),
   .little_endian(little_endian)
);

// *** verification/fcsu_core_model.sv ***
// Far-side model of scoreboard, units and load/store cache flush.
`timescale 1ns/1ps
module fcsu_core_model import fcsu_pkg::*; (
   input wire logic sys_clk,
   input wire logic lsu_flush_req,
   input wire logic [2:0] busy,
   output fcsu_core_status_t core_status
);
   logic [1:0] cnt_q = 2'h0;
   // A flush takes three cycles so a barrier that ignored it would show.
   always_ff @(posedge sys_clk) begin
      cnt_q <= lsu_flush_req ? 2'h3 : cnt_q - {1'b0, cnt_q != 2'h0};
   end
   assign core_status = {~busy, cnt_q == 2'h0};
endmodule // fcsu_core_model

// *** verification/flow_control_serialize_unit_test.sv ***
// Self-checking testbench for the flow-control serialize unit.
`timescale 1ns/1ps
module flow_control_serialize_unit_test;
   import fcsu_pkg::*;
   logic sys_clk = 1'b0;
   logic resetn = 1'b0;
   logic instr_valid = 1'b0;
   logic [31:0] instr_word = 32'h0;
   logic user_mode = 1'b0;
   logic exception_req = 1'b0;
   logic [2:0] busy = 3'h0;
   logic instr_taken, issue_hold, core_idle, illegal_instr, lsu_flush_req;
   logic little_endian;
   fcsu_core_status_t core_status;
   fcsu_backup_cmd_t backup_cmd;
   int err_total = 0;
   int samples_checked = 0;
   always #2.5 sys_clk = ~sys_clk;
   fcsu_flow_control i_fcsu_flow_control (
      .sys_clk(sys_clk),
      .resetn(resetn),
      .instr_valid(instr_valid),
      .instr_word(instr_word),
      .user_mode(user_mode),
      .exception_req(exception_req),
      .core_status(core_status),
      .instr_taken(instr_taken),
      .issue_hold(issue_hold),
      .core_idle(core_idle),
      .illegal_instr(illegal_instr),
      .lsu_flush_req(lsu_flush_req),
      .backup_cmd(backup_cmd),
      .little_endian(little_endian)
   );
   fcsu_core_model i_fcsu_core_model (
      .sys_clk(sys_clk),
      .lsu_flush_req(lsu_flush_req),
      .busy(busy),
      .core_status(core_status)
   );
   task automatic give_verdict;
      $display("checked %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic cmp(input string what, input logic [3:0] exp, got);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic cmp_bit(input string what, input logic exp, got);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch %s expected %b seen %b", what, exp, got);
      end
   endtask
   task automatic cycles(input int k);
      repeat (k) @(posedge sys_clk);
      @(negedge sys_clk);
   endtask
   // Holds the word until taken; returns in the cycle after the take.
   task automatic issue(input logic [7:0] op, input logic [23:0] lo,
                        input logic u);
      int n;
      @(posedge sys_clk);
      instr_valid <= 1'b1;
      instr_word <= {op, lo};
      user_mode <= u;
      n = 0;
      do begin
         @(negedge sys_clk);
         n++;
      end while (instr_taken !== 1'b1 && n < 99);
      if (instr_taken !== 1'b1) begin
         err_total++;
         $display("mismatch issue expected 1 seen %b", instr_taken);
      end
      @(posedge sys_clk);
      instr_valid <= 1'b0;
      @(negedge sys_clk);
   endtask
   task automatic wake;
      @(posedge sys_clk);
      exception_req <= 1'b1;
      @(posedge sys_clk);
      @(posedge sys_clk);
      exception_req <= 1'b0;
      cycles(0);
      cmp_bit("wake", 1'b0, core_idle);
   endtask
   initial begin
      repeat (8) @(posedge sys_clk);
      resetn <= 1'b1;
      issue(DEF_SAVE_OPC, 24'h0, 1'b1);
      cmp("save", 4'h2, backup_cmd);
      cmp_bit("save_hold", 1'b0, issue_hold);
      issue(DEF_RESTORE_OPC, 24'h0, 1'b1);
      cmp("restore", 4'h1, backup_cmd);
      issue(DEF_RETURN_OPC, 24'h0, 1'b0);
      cmp("return", 4'h4, backup_cmd);
      issue(DEF_IDLE_OPC, 24'h0, 1'b1);
      cmp("switch", 4'h8, backup_cmd);
      cycles(6);
      cmp_bit("idle", 1'b1, core_idle);
      wake();
      issue(DEF_IDLE_OPC, 24'h0, 1'b0);
      cmp("super", 4'h0, backup_cmd);
      wake();
      issue(DEF_IDLE_OPC, 24'h1, 1'b1);
      cmp_bit("bad_idle", 1'b1, illegal_instr);
      cmp_bit("bad_idle_run", 1'b0, core_idle);
      for (int i = 0; i < 3; i++) begin
         @(posedge sys_clk);
         busy <= 3'h7;
         issue(DEF_BARRIER_OPC, 24'h800000 >> i, 1'b0);
         cycles(4);
         cmp_bit("wait", 1'b1, issue_hold);
         @(posedge sys_clk);
         busy <= 3'h7 & ~(3'h4 >> i);
         cycles(3);
         cmp_bit("go", 1'b0, issue_hold);
      end
      // Three flags at once: two conditions met must not release issue.
      @(posedge sys_clk);
      busy <= 3'h7;
      issue(DEF_BARRIER_OPC, 24'hE00000, 1'b0);
      @(posedge sys_clk);
      busy <= 3'h4;
      cycles(3);
      cmp_bit("and_wait", 1'b1, issue_hold);
      @(posedge sys_clk);
      busy <= 3'h0;
      cycles(3);
      cmp_bit("and_go", 1'b0, issue_hold);
      issue(DEF_BARRIER_OPC, 24'h100000, 1'b0);
      cmp_bit("flush", 1'b1, lsu_flush_req);
      cmp_bit("flush_hold", 1'b1, issue_hold);
      cycles(3);
      cmp_bit("flush_wait", 1'b1, issue_hold);
      cycles(5);
      cmp_bit("flush_go", 1'b0, issue_hold);
      issue(DEF_BARRIER_OPC, 24'h1, 1'b0);
      cmp_bit("rsvd", 1'b1, illegal_instr);
      cmp_bit("rsvd_hold", 1'b0, issue_hold);
      // A reset in mid-run must drop the core out of idle.
      issue(DEF_IDLE_OPC, 24'h0, 1'b0);
      @(posedge sys_clk);
      resetn <= 1'b0;
      @(posedge sys_clk);
      resetn <= 1'b1;
      cycles(0);
      cmp_bit("reset_idle", 1'b0, core_idle);
      cmp_bit("reset_hold", 1'b0, issue_hold);
      cmp_bit("endian", 1'b1, little_endian);
      give_verdict();
   end
   initial begin
      #20000;
      err_total++;
      give_verdict();
   end
endmodule // flow_control_serialize_unit_test
